// >>> verilog/swt_regs.vh
`ifndef SWT_REGS_VH
`define SWT_REGS_VH

// Register offsets on the 8-bit register port.
`define SWT_ADDR_PORT_A 3'h0
`define SWT_ADDR_KBD_SC 3'h1
`define SWT_ADDR_KBD_IE 3'h2
`define SWT_ADDR_CFG1 3'h3
`define SWT_ADDR_INT_STAT 3'h4
`define SWT_ADDR_INT_MASK 3'h5

// Port A data register fields.
`define SWT_PA_LATCH_BIT 6
`define SWT_PA_DATA_MSB 5

// Keyboard status and control register fields.
`define SWT_SC_PEND_BIT 3
`define SWT_SC_ACK_BIT 2
`define SWT_SC_MASK_BIT 1

// Keyboard interrupt enable register fields.
`define SWT_IE_WAKE_BIT 6
`define SWT_IE_PIN_MSB 5

// Configuration register one fields.
`define SWT_CFG_PSEL_BIT 0

// Interrupt status and mask fields.
`define SWT_INT_OVF_BIT 0
`define SWT_INT_WAKE_BIT 1
`define SWT_INT_MSB 1

// Reset values.
`define SWT_RST_PA_DATA 6'h00
`define SWT_RST_KBD_MASK 1'b0
`define SWT_RST_KBD_IE 7'h00
`define SWT_RST_CFG1 1'b0
`define SWT_RST_INT 2'h0

// Timing: system clock, wakeup oscillator period and the two wakeup periods.
`define SWT_CLK_NS 40
`define SWT_RC_PERIOD_NS 1000
`define SWT_LONG_MS 650
`define SWT_SHORT_MS 16
// Sized so they meet their 8 and 24 bit users without truncation: 1000/40, 650 ms and 16 ms.
`define SWT_RC_DIV 8'h19
`define SWT_LONG_TICKS 24'h09eb10
`define SWT_SHORT_TICKS 24'h003e80

`endif

// >>> verilog/swt_rc_counter.v
`timescale 1ns/1ps
module swt_rc_counter #(
  parameter [7:0] RC_DIV = 8'h19,
  parameter [23:0] LONG_TICKS = 24'h09eb10,
  parameter [23:0] SHORT_TICKS = 24'h003e80
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Control
  input wire runEnable,
  input wire periodSelect,
  // Result
  output reg overflowPulse
);

  reg [7:0] divCount_reg;
  reg [23:0] tickCount_reg;
  wire rcTick;
  wire [23:0] limit;

  // The dedicated oscillator is stood in for by a tick divider that only runs while enabled.
  assign rcTick = (divCount_reg == RC_DIV - 8'h01);
  assign limit = periodSelect ? SHORT_TICKS : LONG_TICKS;

  always @(posedge clk)
  begin
    if (!rst_n || !runEnable)
    begin
      // Held at zero outside stop so every stop period is timed from its start.
      divCount_reg <= 8'h00;
      tickCount_reg <= 24'h000000;
      overflowPulse <= 1'b0;
    end
    else
    begin
      overflowPulse <= 1'b0;
      if (rcTick)
      begin
        divCount_reg <= 8'h00;
        if (tickCount_reg == limit - 24'h000001)
        begin
          tickCount_reg <= 24'h000000;
          overflowPulse <= 1'b1;
        end
        else
        begin
          tickCount_reg <= tickCount_reg + 24'h000001;
        end
      end
      else
      begin
        divCount_reg <= divCount_reg + 8'h01;
      end
    end
  end

endmodule // swt_rc_counter

// >>> verilog/swt_wakeup_timer.v
// What this block does
// - Internal periodic wakeups act as keyboard interrupts.
// - Request latches when input high and enabled.
// - Latch reads at port A bit six only.
// - Stop entry starts dedicated oscillator and counter.
// - Counter overflow latches request to keyboard logic.
// - Service only if enabled; keyboard vector shared.
// - One bit selects long or short period.
// - Acknowledge write or reset clears the latch.
// - Latch readback ignores the enable bit.
// - Oscillator and counters idle during run.
// - Wait mode produces no wakeup requests.
// - Counters restart from zero each stop entry.
// - Stop exit only while keyboard mask cleared.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "swt_regs.vh"
module swt_wakeup_timer #(
  parameter [23:0] LONG_TICKS = `SWT_LONG_TICKS,
  parameter [23:0] SHORT_TICKS = `SWT_SHORT_TICKS
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Register port
  input wire [2:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdata,
  // Power mode state from the CPU
  input wire stopMode,
  input wire waitMode,
  // Keyboard interrupt path
  output reg kbdIrqReq,
  output reg stopWake,
  output reg rcOscEnable,
  // Interrupt output
  output reg irq
);

  localparam [7:0] RC_DIV = `SWT_RC_DIV;

  reg [`SWT_PA_DATA_MSB:0] portAData_reg;
  reg kbdIrqMask_reg;
  reg [6:0] kbdIrqEnable_reg;
  reg periodSelect_reg;
  reg [`SWT_INT_MSB:0] intStat_reg;
  reg [`SWT_INT_MSB:0] intStat_next;
  reg [`SWT_INT_MSB:0] intMask_reg;
  reg wakeupLatch_reg;
  reg wakeupLatch_next;
  reg stopWakeDone_reg;
  reg [7:0] rdata_next;

  wire wakeupIrqEnable;
  wire timerRun;
  wire wakeupRequestIn;
  wire wrPortA;
  wire wrKbdSc;
  wire wrKbdIe;
  wire wrCfg1;
  wire wrIntStat;
  wire wrIntMask;
  wire ackWrite;
  wire pending;
  wire wakeEvent;

  assign wakeupIrqEnable = kbdIrqEnable_reg[`SWT_IE_WAKE_BIT];

  // The timer runs only in stop with the wakeup enabled; wait mode never starts it.
  assign timerRun = stopMode && !waitMode && wakeupIrqEnable;

  swt_rc_counter #(
    .RC_DIV(RC_DIV),
    .LONG_TICKS(LONG_TICKS),
    .SHORT_TICKS(SHORT_TICKS)
  ) u_counter (
    .clk(clk),
    .rst_n(rst_n),
    .runEnable(timerRun),
    .periodSelect(periodSelect_reg),
    .overflowPulse(wakeupRequestIn)
  );

  assign wrPortA = regWrite && (regAddr == `SWT_ADDR_PORT_A);
  assign wrKbdSc = regWrite && (regAddr == `SWT_ADDR_KBD_SC);
  assign wrKbdIe = regWrite && (regAddr == `SWT_ADDR_KBD_IE);
  assign wrCfg1 = regWrite && (regAddr == `SWT_ADDR_CFG1);
  assign wrIntStat = regWrite && (regAddr == `SWT_ADDR_INT_STAT);
  assign wrIntMask = regWrite && (regAddr == `SWT_ADDR_INT_MASK);
  assign ackWrite = wrKbdSc && regWdata[`SWT_SC_ACK_BIT];

  // Wakeup latch: a new request in the same cycle as the acknowledge wins.
  always @*
  begin
    wakeupLatch_next = wakeupLatch_reg;
    if (ackWrite)
    begin
      wakeupLatch_next = 1'b0;
    end
    if (wakeupRequestIn && wakeupIrqEnable)
    begin
      wakeupLatch_next = 1'b1;
    end
  end

  // A latched request is only a keyboard interrupt while enabled.
  assign pending = wakeupLatch_reg && wakeupIrqEnable;

  // Stop exit is gated by the keyboard mask.
  assign wakeEvent = pending && !kbdIrqMask_reg && stopMode && !stopWakeDone_reg;

  always @*
  begin
    intStat_next = intStat_reg;
    if (wrIntStat)
    begin
      intStat_next = intStat_reg & ~regWdata[`SWT_INT_MSB:0];
    end
    if (wakeupRequestIn)
    begin
      intStat_next[`SWT_INT_OVF_BIT] = 1'b1;
    end
    if (wakeEvent)
    begin
      intStat_next[`SWT_INT_WAKE_BIT] = 1'b1;
    end
  end

  // Read mux; unmapped offsets read as zero.
  always @*
  begin
    rdata_next = 8'h00;
    if (regAddr == `SWT_ADDR_PORT_A)
    begin
      rdata_next[`SWT_PA_DATA_MSB:0] = portAData_reg;
      // Bit six is read only and shows the latch whatever the enable says.
      rdata_next[`SWT_PA_LATCH_BIT] = wakeupLatch_reg;
    end
    else if (regAddr == `SWT_ADDR_KBD_SC)
    begin
      rdata_next[`SWT_SC_PEND_BIT] = pending;
      rdata_next[`SWT_SC_MASK_BIT] = kbdIrqMask_reg;
    end
    else if (regAddr == `SWT_ADDR_KBD_IE)
    begin
      rdata_next[6:0] = kbdIrqEnable_reg;
    end
    else if (regAddr == `SWT_ADDR_CFG1)
    begin
      rdata_next[`SWT_CFG_PSEL_BIT] = periodSelect_reg;
    end
    else if (regAddr == `SWT_ADDR_INT_STAT)
    begin
      rdata_next[`SWT_INT_MSB:0] = intStat_reg;
    end
    else if (regAddr == `SWT_ADDR_INT_MASK)
    begin
      rdata_next[`SWT_INT_MSB:0] = intMask_reg;
    end
  end

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      portAData_reg <= `SWT_RST_PA_DATA;
      kbdIrqMask_reg <= `SWT_RST_KBD_MASK;
      kbdIrqEnable_reg <= `SWT_RST_KBD_IE;
      periodSelect_reg <= `SWT_RST_CFG1;
      intStat_reg <= `SWT_RST_INT;
      intMask_reg <= `SWT_RST_INT;
      wakeupLatch_reg <= 1'b0;
      stopWakeDone_reg <= 1'b0;
      regRdata <= 8'h00;
      kbdIrqReq <= 1'b0;
      stopWake <= 1'b0;
      rcOscEnable <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      if (wrPortA)
      begin
        // Bit six has no storage behind it; only the pin data bits are kept.
        portAData_reg <= regWdata[`SWT_PA_DATA_MSB:0];
      end
      if (wrKbdSc)
      begin
        kbdIrqMask_reg <= regWdata[`SWT_SC_MASK_BIT];
      end
      if (wrKbdIe)
      begin
        kbdIrqEnable_reg <= regWdata[6:0];
      end
      if (wrCfg1)
      begin
        periodSelect_reg <= regWdata[`SWT_CFG_PSEL_BIT];
      end
      if (wrIntMask)
      begin
        intMask_reg <= regWdata[`SWT_INT_MSB:0];
      end
      intStat_reg <= intStat_next;
      wakeupLatch_reg <= wakeupLatch_next;
      // One stop exit pulse per stop period; rearmed when stop ends.
      if (!stopMode)
      begin
        stopWakeDone_reg <= 1'b0;
      end
      else if (wakeEvent)
      begin
        stopWakeDone_reg <= 1'b1;
      end
      if (regRead)
      begin
        regRdata <= rdata_next;
      end
      else
      begin
        regRdata <= 8'h00;
      end
      kbdIrqReq <= wakeupLatch_next && wakeupIrqEnable && !kbdIrqMask_reg;
      stopWake <= wakeEvent;
      rcOscEnable <= timerRun;
      irq <= |(intStat_next & intMask_reg);
    end
  end

endmodule // swt_wakeup_timer

// >>> tb/swt_monitor.sv
`timescale 1ns/1ps
module swt_monitor #(
  parameter [23:0] LONG_TICKS = 24'h000004,
  parameter [23:0] SHORT_TICKS = 24'h000002
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Register port
  input wire [2:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regRdata,
  // Modes and keyboard path
  input wire stopMode,
  input wire waitMode,
  input wire kbdIrqReq,
  input wire stopWake,
  input wire rcOscEnable
);
  // Cycles since the oscillator started; only the first wake of a stop period is timed.
  reg [31:0] runCnt_reg;
  always @(posedge clk)
    runCnt_reg <= (rst_n && rcOscEnable) ? runCnt_reg + 32'h1 : 32'h0;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  osc_idle_run_a: assert property (!stopMode || waitMode |=> !rcOscEnable)
    else $error("oscillator runs outside stop");
  wait_no_wake_a: assert property (waitMode && $past(waitMode) |-> !stopWake)
    else $error("wake request in wait mode");
  wake_pulse_a: assert property (stopWake |=> !stopWake)
    else $error("wake request longer than one cycle");
  wake_needs_req_a: assert property (stopWake |-> kbdIrqReq && $past(stopMode))
    else $error("wake without keyboard request");
  osc_start_a: assert property ($rose(rcOscEnable) |-> $past(stopMode))
    else $error("oscillator started outside stop");
  wake_period_a: assert property (stopWake |-> runCnt_reg inside
    {[25*SHORT_TICKS-2:25*SHORT_TICKS+3], [25*LONG_TICKS-2:25*LONG_TICKS+3]})
    else $error("wake period wrong");
  read_window_a: assert property (!$past(regRead) |-> regRdata == 8'h00)
    else $error("read data outside its cycle");
  ack_clears_a: assert property (regWrite && regAddr == 3'h1 && regWdata[2] && !stopMode
    |=> ##1 !kbdIrqReq)
    else $error("acknowledge left request set");
endmodule // swt_monitor

// >>> tb/swt_cpu_model.sv
`timescale 1ns/1ps
module swt_cpu_model (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Bench requests
  input wire stopReq,
  input wire leaveReq,
  input wire waitReq,
  // Device side
  input wire stopWake,
  output reg stopMode,
  output reg waitMode
);
  // The core leaves stop on the first wake it sees, like any keyboard interrupt.
  always @(posedge clk)
  begin
    stopMode <= rst_n && !stopWake && !leaveReq && (stopReq || stopMode);
    waitMode <= rst_n && waitReq;
  end
endmodule // swt_cpu_model

// >>> tb/swt_wakeup_timer_tb_top.sv
`timescale 1ns/1ps
module swt_wakeup_timer_tb_top;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [2:0] regAddr = 3'h0;
  reg [7:0] regWdata = 8'h00;
  reg regWrite = 1'b0;
  reg regRead = 1'b0;
  reg stopReq = 1'b0;
  reg leaveReq = 1'b0;
  reg waitReq = 1'b0;
  wire [7:0] regRdata;
  wire stopMode, waitMode, kbdIrqReq, stopWake, rcOscEnable, irq;
  integer fails = 0;
  integer tests_run = 0;
  integer n, k;
  reg [7:0] r;
  swt_wakeup_timer #(.LONG_TICKS(24'h000004), .SHORT_TICKS(24'h000002)) swt_wakeup_timer_i (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .stopMode(stopMode), .waitMode(waitMode),
    .kbdIrqReq(kbdIrqReq), .stopWake(stopWake), .rcOscEnable(rcOscEnable), .irq(irq));
  swt_cpu_model swt_cpu_model_i (.clk(clk), .rst_n(rst_n), .stopReq(stopReq),
    .leaveReq(leaveReq), .waitReq(waitReq), .stopWake(stopWake), .stopMode(stopMode),
    .waitMode(waitMode));
  initial forever #20 clk = ~clk;
  function integer wakeCycles(input integer sel);
    wakeCycles = 25 * (sel ? 2 : 4);
  endfunction
  task chk(input [7:0] seen, input [7:0] exp);
  begin
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask
  task wr(input [2:0] a, input [7:0] d);
  begin
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
  end
  endtask
  task rd(input [2:0] a, input [7:0] exp);
  begin
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    chk(regRdata, exp);
    @(posedge clk);
  end
  endtask
  task stopRun(input integer lim, input reg expectWake);
  begin
    stopReq <= 1'b1;
    @(posedge clk);
    stopReq <= 1'b0;
    n = 0;
    while (stopWake !== 1'b1 && n < lim)
    begin
      @(negedge clk);
      n = n + 1;
    end
    // A wake that never comes is a hang, not a pass.
    if (expectWake && stopWake !== 1'b1)
    begin
      fails = fails + 1;
      conclude;
    end
    @(posedge clk);
    leaveReq <= 1'b1;
    @(posedge clk);
    leaveReq <= 1'b0;
  end
  endtask
  task conclude;
  begin
    if (fails == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  initial
  begin
    n = $urandom(32'h36e6f969);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({7'h00, rcOscEnable}, 8'h00);
    wr(3'h7, 8'hff);
    for (k = 0; k < 8; k = k + 1)
      rd(k[2:0], 8'h00);
    r = 8'($urandom);
    wr(3'h0, r | 8'hc0);
    rd(3'h0, {2'b00, r[5:0]});
    wr(3'h2, 8'h40);
    for (k = 0; k < 2; k = k + 1)
    begin
      wr(3'h3, k[7:0]);
      wr(3'h5, {6'h00, k[0], k[0]});
      stopRun(30, 1'b0);
      chk(n[7:0], 8'h1e);
      stopRun(200, 1'b1);
      chk({7'h00, n >= wakeCycles(k) && n <= wakeCycles(k) + 6}, 8'h01);
      rd(3'h0, {2'b01, r[5:0]});
      rd(3'h1, 8'h08);
      rd(3'h4, 8'h03);
      @(negedge clk);
      chk({7'h00, kbdIrqReq}, 8'h01);
      chk({7'h00, irq}, k[7:0]);
      @(posedge clk);
      wr(3'h2, 8'h00);
      rd(3'h0, {2'b01, r[5:0]});
      wr(3'h2, 8'h40);
      wr(3'h1, 8'h04);
      wr(3'h4, 8'h03);
      rd(3'h0, {2'b00, r[5:0]});
      @(negedge clk);
      chk({7'h00, irq}, 8'h00);
      @(posedge clk);
    end
    waitReq <= 1'b1;
    stopRun(150, 1'b0);
    chk(n[7:0], 8'h96);
    rd(3'h0, {2'b00, r[5:0]});
    waitReq <= 1'b0;
    wr(3'h1, 8'h02);
    stopRun(150, 1'b0);
    chk(n[7:0], 8'h96);
    rd(3'h1, 8'h0a);
    wr(3'h1, 8'h06);
    rd(3'h0, {2'b00, r[5:0]});
    conclude;
  end
endmodule // swt_wakeup_timer_tb_top
bind swt_wakeup_timer swt_monitor #(.LONG_TICKS(LONG_TICKS), .SHORT_TICKS(SHORT_TICKS))
  swt_monitor_i (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .stopMode(stopMode),
  .waitMode(waitMode), .kbdIrqReq(kbdIrqReq), .stopWake(stopWake),
  .rcOscEnable(rcOscEnable));
